/* File: rtl/sidd_regs.svh */
// Register offsets, field positions and reset values of the subtract and step datapath.
`ifndef SIDD_REGS_SVH
`define SIDD_REGS_SVH

// Byte offsets of the register words on the APB side.
`define SIDD_WORK_OFS     8'h00
`define SIDD_OPND_OFS     8'h04
`define SIDD_STAT_OFS     8'h08
`define SIDD_CMD_OFS      8'h0C
`define SIDD_MEMRES_OFS   8'h10

// Command word fields.
`define SIDD_CMD_OP_HI    2
`define SIDD_CMD_OP_LO    0
`define SIDD_CMD_DEST_BIT 3
`define SIDD_OP_LAST      3'h4

// Status word bit positions.
`define SIDD_ST_ZERO      0
`define SIDD_ST_BORROW    1
`define SIDD_ST_HALF      2
`define SIDD_ST_RANGE     3

// Reset values.
`define SIDD_DATA_RST     8'h00
`define SIDD_FLAG_RST     1'b0

`endif

/* File: rtl/sidd_pkg.sv */
// Types shared by the subtract and step datapath.
package sidd_pkg;
    typedef enum logic [2:0] {
        SIDD_OP_SUB,
        SIDD_OP_SUBC,
        SIDD_OP_SUBC_SGL,
        SIDD_OP_INC,
        SIDD_OP_DEC
    } sidd_op_t;
endpackage

/* File: rtl/sidd_alu.sv */
// Adder that forms sums and differences with borrow, half borrow and range fault.
`timescale 1ns/100ps
`default_nettype none
module sidd_alu #(
    parameter int DW = 8
) (
    input  wire logic [DW-1:0] a,
    input  wire logic [DW-1:0] b,
    input  wire logic          cin,
    input  wire logic          sub,
    output logic      [DW-1:0] res,
    output logic               cout,
    output logic               half,
    output logic               ovf
);
    logic [DW-1:0] bx;
    logic          cx;
    logic [DW:0]   full;
    logic [4:0]    low;

    // Subtraction adds the complement of b and the inverted borrow in.
    always_comb begin
        bx   = sub ? ~b : b;
        cx   = sub ? ~cin : cin;
        full = {1'b0, a} + {1'b0, bx} + {{DW{1'b0}}, cx};
        low  = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
        res  = full[DW-1:0];
        cout = sub ? ~full[DW] : full[DW];
        half = sub ? ~low[4] : low[4];
        ovf  = (a[DW-1] == bx[DW-1]) && (res[DW-1] != a[DW-1]);
    end
endmodule
`default_nettype wire

/* File: rtl/sidd_datapath.sv */
// Subtract, subtract-with-borrow, increment and decrement datapath with APB registers.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "sidd_regs.svh"
module sidd_datapath #(
    parameter int DW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic      [DW-1:0] work_out,
    output logic               mem_wr_en,
    output logic      [DW-1:0] mem_wr_data
);
    generate
        if (DW < 5 || DW > 32) begin : g_bad_width
            $error("sidd_datapath: DW must lie between 5 and 32");
        end
    endgenerate

    logic [DW-1:0]         work_ff;
    logic [DW-1:0]         opnd_ff;
    logic [DW-1:0]         memres_ff;
    logic                  zero_ff;
    logic                  borrow_ff;
    logic                  half_ff;
    logic                  range_ff;
    logic                  exec_ff;
    logic                  dest_mem_ff;
    sidd_pkg::sidd_op_t    op_ff;
    logic                  pready_ff;
    logic                  pslverr_ff;
    logic [31:0]           prdata_ff;
    logic                  mem_wr_en_ff;
    logic [DW-1:0]         mem_wr_data_ff;
    logic                  xfer;
    logic                  wr_cmd;
    logic [DW-1:0]         alu_a;
    logic [DW-1:0]         alu_b;
    logic                  alu_cin;
    logic                  alu_sub;
    logic [DW-1:0]         alu_res;
    logic                  alu_cout;
    logic                  alu_half;
    logic                  alu_ovf;
    logic                  to_mem;
    logic                  cmd_ok;

    // Returns one when the address names a mapped register word.
    function automatic logic addr_ok(input logic [7:0] addr);
        addr_ok = (addr == `SIDD_WORK_OFS) || (addr == `SIDD_OPND_OFS) ||
                  (addr == `SIDD_STAT_OFS) || (addr == `SIDD_CMD_OFS) ||
                  (addr == `SIDD_MEMRES_OFS);
    endfunction

    // Returns one when a bus write of that address in this cycle completes.
    function automatic logic wr_hit(input logic [7:0] offs);
        wr_hit = xfer && pwrite && (paddr == offs);
    endfunction

    // A transfer completes when the registered ready meets the access phase.
    assign xfer   = psel && penable && pready_ff;
    assign cmd_ok = pwdata[`SIDD_CMD_OP_HI:`SIDD_CMD_OP_LO] <= `SIDD_OP_LAST;
    assign wr_cmd = wr_hit(`SIDD_CMD_OFS) && cmd_ok;

    // Selects adder operands from the latched command.
    always_comb begin
        alu_a   = work_ff;
        alu_b   = opnd_ff;
        alu_cin = 1'b0;
        alu_sub = 1'b1;
        to_mem  = dest_mem_ff;
        case (op_ff)
            sidd_pkg::SIDD_OP_SUB: begin
                alu_a = dest_mem_ff ? opnd_ff : work_ff;
                alu_b = dest_mem_ff ? work_ff : opnd_ff;
            end
            sidd_pkg::SIDD_OP_SUBC: begin
                alu_a   = dest_mem_ff ? opnd_ff : work_ff;
                alu_b   = dest_mem_ff ? work_ff : opnd_ff;
                alu_cin = borrow_ff;
            end
            sidd_pkg::SIDD_OP_SUBC_SGL: begin
                alu_a   = dest_mem_ff ? opnd_ff : work_ff;
                alu_b   = '0;
                alu_cin = borrow_ff;
            end
            sidd_pkg::SIDD_OP_INC: begin
                alu_a   = opnd_ff;
                alu_b   = '0;
                alu_cin = 1'b1;
                alu_sub = 1'b0;
                to_mem  = 1'b1;
            end
            sidd_pkg::SIDD_OP_DEC: begin
                alu_a   = opnd_ff;
                alu_b   = '0;
                alu_cin = 1'b1;
                to_mem  = 1'b1;
            end
            default: begin
                alu_a   = work_ff;
                alu_b   = opnd_ff;
            end
        endcase
    end

    sidd_alu #(
        .DW (DW)
    ) u_alu (
        .a    (alu_a),
        .b    (alu_b),
        .cin  (alu_cin),
        .sub  (alu_sub),
        .res  (alu_res),
        .cout (alu_cout),
        .half (alu_half),
        .ovf  (alu_ovf)
    );

    // Latches a valid command; execution follows on the next edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec_ff     <= 1'b0;
            dest_mem_ff <= 1'b0;
            op_ff       <= sidd_pkg::SIDD_OP_SUB;
        end else begin
            exec_ff <= wr_cmd;
            if (wr_cmd) begin
                dest_mem_ff <= pwdata[`SIDD_CMD_DEST_BIT];
                op_ff       <= sidd_pkg::sidd_op_t'(pwdata[`SIDD_CMD_OP_HI:`SIDD_CMD_OP_LO]);
            end
        end
    end

    // Work register: a result bound for it wins over a bus write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_ff <= DW'(`SIDD_DATA_RST);
        end else if (exec_ff && !to_mem) begin
            work_ff <= alu_res;
        end else if (wr_hit(`SIDD_WORK_OFS)) begin
            work_ff <= pwdata[DW-1:0];
        end
    end

    // Operand word written by software for the memory operand.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_ff <= DW'(`SIDD_DATA_RST);
        end else if (wr_hit(`SIDD_OPND_OFS)) begin
            opnd_ff <= pwdata[DW-1:0];
        end
    end

    // Memory write-back strobe and data, also kept for software to read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_wr_en_ff   <= 1'b0;
            mem_wr_data_ff <= DW'(`SIDD_DATA_RST);
            memres_ff      <= DW'(`SIDD_DATA_RST);
        end else begin
            mem_wr_en_ff <= exec_ff && to_mem;
            if (exec_ff && to_mem) begin
                mem_wr_data_ff <= alu_res;
                memres_ff      <= alu_res;
            end
        end
    end

    // Flags follow the result in the write cycle; this update wins over a bus write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_ff   <= `SIDD_FLAG_RST;
            borrow_ff <= `SIDD_FLAG_RST;
            half_ff   <= `SIDD_FLAG_RST;
            range_ff  <= `SIDD_FLAG_RST;
        end else if (exec_ff) begin
            zero_ff   <= (alu_res == '0);
            borrow_ff <= alu_cout;
            half_ff   <= alu_half;
            range_ff  <= alu_ovf;
        end else if (wr_hit(`SIDD_STAT_OFS)) begin
            zero_ff   <= pwdata[`SIDD_ST_ZERO];
            borrow_ff <= pwdata[`SIDD_ST_BORROW];
            half_ff   <= pwdata[`SIDD_ST_HALF];
            range_ff  <= pwdata[`SIDD_ST_RANGE];
        end
    end

    // APB answer: ready rises one cycle into the access phase, with data and error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_ok(paddr);
            prdata_ff  <= 32'h0000_0000;
            if (psel && penable && !pready_ff && !pwrite) begin
                case (paddr)
                    `SIDD_WORK_OFS:   prdata_ff <= 32'(work_ff);
                    `SIDD_OPND_OFS:   prdata_ff <= 32'(opnd_ff);
                    `SIDD_STAT_OFS:   prdata_ff <= 32'({range_ff, half_ff, borrow_ff, zero_ff});
                    `SIDD_CMD_OFS:    prdata_ff <= 32'({dest_mem_ff, op_ff});
                    `SIDD_MEMRES_OFS: prdata_ff <= 32'(memres_ff);
                    default:          prdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs straight from flip-flops.
    assign prdata      = prdata_ff;
    assign pready      = pready_ff;
    assign pslverr     = pslverr_ff;
    assign work_out    = work_ff;
    assign mem_wr_en   = mem_wr_en_ff;
    assign mem_wr_data = mem_wr_data_ff;

    // Checks that each operation lands its result in the right place and that the flags follow the result.
    sub_work_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUB && !dest_mem_ff
        |=> work_ff == $past(work_ff - opnd_ff) && !mem_wr_en_ff)
        else $error("subtract to work register wrong");
    sub_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUB && dest_mem_ff
        |=> mem_wr_en_ff && mem_wr_data_ff == $past(opnd_ff - work_ff) && $stable(work_ff))
        else $error("subtract to memory wrong");
    subc_work_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUBC && !dest_mem_ff
        |=> work_ff == $past(work_ff - opnd_ff - DW'(borrow_ff)))
        else $error("borrow subtract to work register wrong");
    subc_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUBC && dest_mem_ff
        |=> mem_wr_en_ff && mem_wr_data_ff == $past(opnd_ff - work_ff - DW'(borrow_ff)))
        else $error("borrow subtract to memory wrong");
    sgl_work_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUBC_SGL && !dest_mem_ff
        |=> work_ff == $past(work_ff - DW'(borrow_ff)))
        else $error("single borrow subtract on work register wrong");
    sgl_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_SUBC_SGL && dest_mem_ff
        |=> mem_wr_en_ff && mem_wr_data_ff == $past(opnd_ff - DW'(borrow_ff)))
        else $error("single borrow subtract on memory wrong");
    inc_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_INC
        |=> mem_wr_en_ff && mem_wr_data_ff == $past(opnd_ff + DW'(1)) && $stable(work_ff))
        else $error("increment wrong");
    dec_mem_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff && op_ff == sidd_pkg::SIDD_OP_DEC
        |=> mem_wr_en_ff && mem_wr_data_ff == $past(opnd_ff - DW'(1)))
        else $error("decrement wrong");
    flag_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        exec_ff |=> zero_ff == ($past(alu_res) == '0) && borrow_ff == $past(alu_cout)
        && half_ff == $past(alu_half) && range_ff == $past(alu_ovf))
        else $error("flags not updated with the result");
endmodule
`default_nettype wire

/* File: dv/sidd_mem_model.sv */
// Data memory cell that takes the datapath's write-back results.
`timescale 1ns/100ps
`default_nettype none
module sidd_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_wr_en,
    input  wire logic [7:0]  mem_wr_data,
    output logic      [7:0]  mem_word,
    output logic      [15:0] wr_count
);
    // The cell keeps the last write-back and counts strobes, so a lost or extra one shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_word <= 8'h00;
            wr_count <= 16'h0000;
        end else if (mem_wr_en) begin
            mem_word <= mem_wr_data;
            wr_count <= wr_count + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: dv/sidd_datapath_tb.sv */
// Self-checking testbench of the subtract and step datapath.
`timescale 1ns/100ps
`default_nettype none
`include "sidd_regs.svh"
`define SIDD_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module sidd_datapath_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  work_out;
    logic        mem_wr_en;
    logic [7:0]  mem_wr_data;
    logic [7:0]  mem_word;
    logic [15:0] wr_count;
    int          fail_count = 0;
    int          comparisons = 0;
    logic [32:0] rd_notes_q[$];
    logic [7:0]  mem_notes_q[$];

    sidd_datapath #(.DW(8)) u_sidd_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .work_out(work_out), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data));
    sidd_mem_model u_sidd_mem_model (.pclk(pclk), .presetn(presetn), .mem_wr_en(mem_wr_en),
        .mem_wr_data(mem_wr_data), .mem_word(mem_word), .wr_count(wr_count));

    // Clock at 50 MHz.
    always #10 pclk = ~pclk;

    // Expected {flags, result}: flags are range fault, half borrow, borrow or carry, zero.
    function automatic logic [11:0] calc(input logic add, input logic [7:0] a,
                                         input logic [7:0] b, input logic c);
        logic [8:0] full;
        logic [4:0] hf;
        logic       ov;
        if (add) begin
            full = {1'b0, a} + {1'b0, b};
            hf = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            ov = (a[7] == b[7]) && (full[7] != a[7]);
        end else begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, c};
            hf = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
            ov = (a[7] != b[7]) && (full[7] != a[7]);
        end
        return {ov, hf[4], full[8], full[7:0] == 8'h00, full[7:0]};
    endfunction

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // A read notes {pslverr, prdata} before it starts.
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rd_notes_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watcher: each completed read and each write-back is matched with the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_notes_q.size() > 0)
            `SIDD_CHK({pslverr, prdata}, rd_notes_q.pop_front())
        if (mem_wr_en === 1'b1) begin
            `SIDD_CHK(mem_notes_q.size() > 0, 1'b1)
            if (mem_notes_q.size() > 0)
                `SIDD_CHK(mem_wr_data, mem_notes_q.pop_front())
        end
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end

    // Main sequence: every op and destination with random operands and borrow-in.
    initial begin
        logic [7:0]  w;
        logic [7:0]  o;
        logic [3:0]  st;
        logic [2:0]  op;
        logic        dest;
        logic        memd;
        logic [11:0] r;
        logic [7:0]  last_mem;
        logic [3:0]  last_cmd;
        int          nmem;
        void'($urandom(32'h24B0));
        nmem = 0;
        last_mem = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Every output is zero just after reset.
        `SIDD_CHK({prdata, pready, pslverr, mem_wr_en, work_out, mem_wr_data}, 51'h0)
        for (int i = 0; i < 60; i++) begin
            op = 3'(i % 5);
            dest = 1'($urandom);
            w = 8'($urandom);
            o = (i < 10) ? (i[1] ? 8'hFF : 8'h00) : 8'($urandom);
            st = 4'($urandom);
            apb(1'b1, `SIDD_WORK_OFS, {24'h0, w});
            apb(1'b1, `SIDD_OPND_OFS, {24'h0, o});
            apb(1'b1, `SIDD_STAT_OFS, {28'h0, st});
            case (op)
                3'h0: r = dest ? calc(1'b0, o, w, 1'b0) : calc(1'b0, w, o, 1'b0);
                3'h1: r = dest ? calc(1'b0, o, w, st[1]) : calc(1'b0, w, o, st[1]);
                3'h2: r = dest ? calc(1'b0, o, 8'h00, st[1]) : calc(1'b0, w, 8'h00, st[1]);
                3'h3: r = calc(1'b1, o, 8'h01, 1'b0);
                default: r = calc(1'b0, o, 8'h01, 1'b0);
            endcase
            memd = dest || (op > 3'h2);
            if (memd) begin
                mem_notes_q.push_back(r[7:0]);
                nmem++;
                last_mem = r[7:0];
            end
            last_cmd = {dest, op};
            apb(1'b1, `SIDD_CMD_OFS, {28'h0, last_cmd});
            rd(`SIDD_WORK_OFS, {25'h0, memd ? w : r[7:0]});
            `SIDD_CHK(work_out, memd ? w : r[7:0])
            rd(`SIDD_STAT_OFS, {29'h0, r[11:8]});
        end
        // Op codes above four leave status and memory untouched.
        apb(1'b1, `SIDD_STAT_OFS, 32'h0000000A);
        for (int k = 5; k < 8; k++)
            apb(1'b1, `SIDD_CMD_OFS, 32'(k) | 32'h8);
        rd(`SIDD_STAT_OFS, {29'h0, 4'hA});
        rd(`SIDD_CMD_OFS, {29'h0, last_cmd});
        rd(`SIDD_MEMRES_OFS, {25'h0, last_mem});
        // Unmapped place: error, zero data, write ignored.
        apb(1'b1, 8'h14, 32'h000000FF);
        rd(8'h14, {1'b1, 32'h0});
        repeat (3) @(posedge pclk);
        `SIDD_CHK(wr_count, 16'(nmem))
        `SIDD_CHK(mem_word, last_mem)
        `SIDD_CHK(rd_notes_q.size(), 0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
